/* File: hdl/itcr_pkg.sv */
/*
 Shared constants and arithmetic for the three-channel interval timer
 with count readback. Assumes a single 100 MHz system clock.
*/
//
// Summary of operation
// - Counters only ever count down, in every mode and number format.
// - Square-wave mode steps the count down by two per counted clock.
// - Live value readable while counting, directly or through a latch.
// - Latch command snapshots the count; counting continues untouched.
// - A count of zero means 65536 counts in binary, 10000 in BCD, in every mode.
// - Rate mode drives output low one clock every n clocks, then reloads.
// - Terminal-count output low at setup, rises at expiry, stays high.
package itcr_pkg;

   // ==========================================================
   // Bus addresses and control word layout
   localparam logic [1:0] ITCR_ADDR_CTRL = 2'h3;
   localparam int ITCR_CW_SC_LO = 6;
   localparam int ITCR_CW_RW_LO = 4;
   localparam int ITCR_CW_M_LO = 1;
   localparam int ITCR_CW_BCD = 0;

   // ==========================================================
   // Read/load formats and modes
   localparam logic [1:0] ITCR_RW_LATCH = 2'h0;
   localparam logic [1:0] ITCR_RW_LSB = 2'h1;
   localparam logic [1:0] ITCR_RW_MSB = 2'h2;
   localparam logic [1:0] ITCR_RW_BOTH = 2'h3;
   localparam logic [2:0] ITCR_MODE_TC = 3'h0;
   localparam logic [2:0] ITCR_MODE_ONESHOT = 3'h1;
   localparam logic [2:0] ITCR_MODE_RATE = 3'h2;
   localparam logic [2:0] ITCR_MODE_SQ = 3'h3;
   localparam logic [2:0] ITCR_MODE_SWSTB = 3'h4;
   localparam logic [2:0] ITCR_MODE_HWSTB = 3'h5;

   // ==========================================================
   // Reset values
   localparam logic [2:0] ITCR_MODE_RST = 3'h0;
   localparam logic [1:0] ITCR_RW_RST = 2'h3;
   localparam logic [15:0] ITCR_CNT_RST = 16'h0000;
   localparam logic [7:0] ITCR_DATA_RST = 8'h00;

   // ==========================================================
   // One step down, binary or four BCD digits; both wrap at zero
   function automatic logic [15:0] itcr_dec(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic brw;
      r = v;
      brw = 1'b1;
      if (!bcd) begin
         r = v - 16'h0001;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (brw) begin
               if (v[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = 4'h9;
               end else begin
                  r[4*i +: 4] = v[4*i +: 4] - 4'h1;
                  brw = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : itcr_dec

endpackage : itcr_pkg

/* File: hdl/itcr_chan.sv */
/*
 One 16-bit down-counter channel with its output waveform logic.
 Assumes tick and gate-rise strobes and registered mode/value from the top.
*/
`timescale 1ns/100ps
`default_nettype none
module itcr_chan
   import itcr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_gate,
   input wire logic i_gate_rise,
   input wire logic i_mode_set,
   input wire logic i_load,
   input wire logic [2:0] i_mode,
   input wire logic i_bcd,
   input wire logic [15:0] i_value,
   output logic [15:0] o_count,
   output logic o_out
);

   // ==========================================================
   // Channel state
   logic [15:0] cnt_reg;
   logic [15:0] val_reg;
   logic out_reg;
   logic pend_reg;
   logic run_reg;
   logic armed_reg;
   logic hw_trig;
   logic mode23;
   logic count_en;
   logic [15:0] sq_hi;
   logic [15:0] sq_lo;

   assign hw_trig = (i_mode == ITCR_MODE_ONESHOT) || (i_mode == ITCR_MODE_HWSTB);
   assign mode23 = (i_mode == ITCR_MODE_RATE) || (i_mode == ITCR_MODE_SQ);
   assign count_en = run_reg && (hw_trig || i_gate);
   // Odd square counts: longer high half, shorter low half
   assign sq_hi = val_reg + {15'h0000, val_reg[0]};
   assign sq_lo = val_reg - {15'h0000, val_reg[0]};
   assign o_count = cnt_reg;
   assign o_out = out_reg;

   // ==========================================================
   // Reload value and start control
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         val_reg <= ITCR_CNT_RST;
         armed_reg <= 1'b0;
      end else if (i_ce) begin
         if (i_load) begin
            val_reg <= i_value;
         end
         if (i_mode_set) begin
            armed_reg <= 1'b0;
         end else if (i_load) begin
            armed_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pend_reg <= 1'b0;
      end else if (i_ce) begin
         if (i_mode_set) begin
            pend_reg <= 1'b0;
         end else if (i_load && !hw_trig && (!run_reg || !mode23)) begin
            pend_reg <= 1'b1;
         end else if (i_gate_rise && armed_reg && (i_mode != ITCR_MODE_TC)) begin
            pend_reg <= 1'b1;
         end else if (i_tick) begin
            pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_reg <= 1'b0;
      end else if (i_ce) begin
         if (i_mode_set) begin
            run_reg <= 1'b0;
         end else if (i_tick && pend_reg) begin
            run_reg <= 1'b1;
         end else if (i_tick && count_en && cnt_reg == 16'h0001 &&
                      (i_mode == ITCR_MODE_SWSTB || i_mode == ITCR_MODE_HWSTB)) begin
            run_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Down-counter; zero count wraps, giving 65536 counts in binary, 10000 in BCD
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_reg <= ITCR_CNT_RST;
      end else if (i_ce && i_tick) begin
         if (pend_reg) begin
            cnt_reg <= (i_mode == ITCR_MODE_SQ) ? sq_hi : val_reg;
         end else if (count_en) begin
            case (i_mode)
               ITCR_MODE_RATE: begin
                  cnt_reg <= (cnt_reg == 16'h0001) ? val_reg : itcr_dec(cnt_reg, i_bcd);
               end
               ITCR_MODE_SQ: begin
                  if (cnt_reg == 16'h0002) begin
                     cnt_reg <= out_reg ? sq_lo : sq_hi;
                  end else begin
                     cnt_reg <= itcr_dec(itcr_dec(cnt_reg, i_bcd), i_bcd);
                  end
               end
               default: begin
                  cnt_reg <= itcr_dec(cnt_reg, i_bcd);
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Output waveform
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_reg <= 1'b1;
      end else if (i_ce) begin
         if (i_mode_set) begin
            out_reg <= (i_mode != ITCR_MODE_TC);
         end else if (i_load && i_mode == ITCR_MODE_TC) begin
            out_reg <= 1'b0;
         end else if (mode23 && !i_gate) begin
            out_reg <= 1'b1;
         end else if (i_tick && pend_reg) begin
            out_reg <= !(i_mode == ITCR_MODE_TC || i_mode == ITCR_MODE_ONESHOT);
         end else if (i_tick && !out_reg && (i_mode == ITCR_MODE_SWSTB || i_mode == ITCR_MODE_HWSTB)) begin
            out_reg <= 1'b1;
         end else if (i_tick && count_en) begin
            case (i_mode)
               ITCR_MODE_TC, ITCR_MODE_ONESHOT: begin
                  if (cnt_reg == 16'h0001) begin
                     out_reg <= 1'b1;
                  end
               end
               ITCR_MODE_RATE: begin
                  out_reg <= (cnt_reg != 16'h0002);
               end
               ITCR_MODE_SQ: begin
                  if (cnt_reg == 16'h0002) begin
                     out_reg <= !out_reg;
                  end
               end
               default: begin
                  out_reg <= (cnt_reg != 16'h0001);
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Checks
   a_never_counts_up: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_tick && count_en && !pend_reg && !i_bcd && i_mode != ITCR_MODE_SQ &&
       !(i_mode == ITCR_MODE_RATE && cnt_reg == 16'h0001)) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("counter did not step down by one");
   a_square_step_two: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_tick && count_en && !pend_reg && !i_bcd && i_mode == ITCR_MODE_SQ &&
       cnt_reg != 16'h0002) |=> cnt_reg == $past(cnt_reg) - 16'h0002)
      else $error("square mode did not step by two");
   a_zero_full_range: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_tick && count_en && !pend_reg && !i_bcd && i_mode == ITCR_MODE_TC &&
       cnt_reg == 16'h0000) |=> cnt_reg == 16'hFFFF)
      else $error("zero count did not wrap to full range");
   a_rate_low_one: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_tick && count_en && !pend_reg && i_gate && i_mode == ITCR_MODE_RATE &&
       cnt_reg == 16'h0002 && !i_mode_set) |=> !out_reg && cnt_reg == 16'h0001)
      else $error("rate pulse did not start at count one");
   a_rate_low_only: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!out_reg && i_mode == ITCR_MODE_RATE && !i_mode_set) |-> cnt_reg == 16'h0001)
      else $error("rate output low away from count one");
   a_terminal_rise: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_tick && count_en && !pend_reg && i_mode == ITCR_MODE_TC && cnt_reg == 16'h0001 &&
       !i_load && !i_mode_set) |=> out_reg)
      else $error("terminal count did not raise output");
   a_terminal_stays: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (out_reg && i_mode == ITCR_MODE_TC && !i_load && !i_mode_set) |=> out_reg)
      else $error("terminal output fell without reprogramming");

endmodule : itcr_chan
`default_nettype wire

/* File: hdl/itcr_top.sv */
/*
 Three-channel interval timer: 8-bit host bus, control words, count
 loading, latch command and byte-wise readback. Assumes all pins are
 synchronous to i_mclk and counter clocks run well below it.
*/
`timescale 1ns/100ps
`default_nettype none
module itcr_top
   import itcr_pkg::*;
#(
   parameter int NUM_CH = 3
)
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_cs_b,
   input wire logic i_rd_b,
   input wire logic i_wr_b,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe_b,
   input wire logic [NUM_CH-1:0] i_cnt_clk,
   input wire logic [NUM_CH-1:0] i_gate,
   output logic [NUM_CH-1:0] o_out
);

   // ==========================================================
   // Bus strobes and pin edges
   logic wr_prev_reg;
   logic rd_prev_reg;
   logic [NUM_CH-1:0] clk_prev_reg;
   logic [NUM_CH-1:0] gate_prev_reg;
   logic wr_end;
   logic rd_end;
   logic [NUM_CH-1:0] tick;
   logic [NUM_CH-1:0] gate_rise;

   // Accesses take effect at the trailing edge of the strobe
   assign wr_end = !wr_prev_reg && i_wr_b && !i_cs_b;
   assign rd_end = !rd_prev_reg && i_rd_b && !i_cs_b;
   assign tick = i_cnt_clk & ~clk_prev_reg;
   assign gate_rise = i_gate & ~gate_prev_reg;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_prev_reg <= 1'b1;
         rd_prev_reg <= 1'b1;
         clk_prev_reg <= '0;
         gate_prev_reg <= '0;
      end else if (i_ce) begin
         wr_prev_reg <= i_wr_b;
         rd_prev_reg <= i_rd_b;
         clk_prev_reg <= i_cnt_clk;
         gate_prev_reg <= i_gate;
      end
   end

   // ==========================================================
   // Per-channel programming and readback state
   logic [2:0] mode_reg [NUM_CH];
   logic [1:0] rw_reg [NUM_CH];
   logic [NUM_CH-1:0] bcd_reg;
   logic [NUM_CH-1:0] mset_reg;
   logic [NUM_CH-1:0] load_reg;
   logic [NUM_CH-1:0] wflip_reg;
   logic [NUM_CH-1:0] rflip_reg;
   logic [NUM_CH-1:0] latched_reg;
   logic [7:0] lsb_reg [NUM_CH];
   logic [15:0] value_reg [NUM_CH];
   logic [15:0] latch_val_reg [NUM_CH];
   logic [15:0] cnt_w [NUM_CH];
   logic [7:0] rd_byte [NUM_CH];
   logic [7:0] data_reg;
   logic oe_b_reg;

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic cw_hit;
      logic cmd_latch;
      logic cw_set;
      logic sel_w;
      logic rd_done;
      logic [15:0] src;

      assign cw_hit = wr_end && i_addr == ITCR_ADDR_CTRL &&
                      i_data[ITCR_CW_SC_LO +: 2] == 2'(ch);
      assign cmd_latch = cw_hit && i_data[ITCR_CW_RW_LO +: 2] == ITCR_RW_LATCH;
      assign cw_set = cw_hit && !cmd_latch;
      assign sel_w = wr_end && i_addr == 2'(ch);
      assign rd_done = rd_end && i_addr == 2'(ch);
      // Live value unless a snapshot is pending readout
      assign src = latched_reg[ch] ? latch_val_reg[ch] : cnt_w[ch];
      assign rd_byte[ch] = (rw_reg[ch] == ITCR_RW_MSB ||
                            (rw_reg[ch] == ITCR_RW_BOTH && rflip_reg[ch])) ? src[15:8] : src[7:0];

      // Control word: modes 6 and 7 alias onto 2 and 3
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            mode_reg[ch] <= ITCR_MODE_RST;
            rw_reg[ch] <= ITCR_RW_RST;
            bcd_reg[ch] <= 1'b0;
            mset_reg[ch] <= 1'b0;
         end else if (i_ce) begin
            mset_reg[ch] <= cw_set;
            if (cw_set) begin
               mode_reg[ch] <= (i_data[ITCR_CW_M_LO + 2] && i_data[ITCR_CW_M_LO + 1]) ?
                               {1'b0, i_data[ITCR_CW_M_LO +: 2]} : i_data[ITCR_CW_M_LO +: 3];
               rw_reg[ch] <= i_data[ITCR_CW_RW_LO +: 2];
               bcd_reg[ch] <= i_data[ITCR_CW_BCD];
            end
         end
      end

      // Count loading, one or two bytes, low byte first
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            wflip_reg[ch] <= 1'b0;
            load_reg[ch] <= 1'b0;
            lsb_reg[ch] <= ITCR_DATA_RST;
            value_reg[ch] <= ITCR_CNT_RST;
         end else if (i_ce) begin
            load_reg[ch] <= 1'b0;
            if (cw_set) begin
               wflip_reg[ch] <= 1'b0;
            end else if (sel_w) begin
               case (rw_reg[ch])
                  ITCR_RW_LSB: begin
                     value_reg[ch] <= {8'h00, i_data};
                     load_reg[ch] <= 1'b1;
                  end
                  ITCR_RW_MSB: begin
                     value_reg[ch] <= {i_data, 8'h00};
                     load_reg[ch] <= 1'b1;
                  end
                  ITCR_RW_BOTH: begin
                     if (!wflip_reg[ch]) begin
                        lsb_reg[ch] <= i_data;
                        wflip_reg[ch] <= 1'b1;
                     end else begin
                        value_reg[ch] <= {i_data, lsb_reg[ch]};
                        wflip_reg[ch] <= 1'b0;
                        load_reg[ch] <= 1'b1;
                     end
                  end
                  default: begin
                     wflip_reg[ch] <= 1'b0;
                  end
               endcase
            end
         end
      end

      // Snapshot: a second latch command before readout is ignored
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            latched_reg[ch] <= 1'b0;
            latch_val_reg[ch] <= ITCR_CNT_RST;
         end else if (i_ce) begin
            if (cw_set) begin
               latched_reg[ch] <= 1'b0;
            end else if (cmd_latch && !latched_reg[ch]) begin
               latched_reg[ch] <= 1'b1;
               latch_val_reg[ch] <= cnt_w[ch];
            end else if (rd_done && (rw_reg[ch] != ITCR_RW_BOTH || rflip_reg[ch])) begin
               latched_reg[ch] <= 1'b0;
            end
         end
      end

      always_ff @(posedge i_mclk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            rflip_reg[ch] <= 1'b0;
         end else if (i_ce) begin
            if (cw_set) begin
               rflip_reg[ch] <= 1'b0;
            end else if (rd_done && rw_reg[ch] == ITCR_RW_BOTH) begin
               rflip_reg[ch] <= !rflip_reg[ch];
            end
         end
      end

      itcr_chan itcr_chan_inst (
         .i_mclk(i_mclk),
         .i_rst_b(i_rst_b),
         .i_ce(i_ce),
         .i_tick(tick[ch]),
         .i_gate(i_gate[ch]),
         .i_gate_rise(gate_rise[ch]),
         .i_mode_set(mset_reg[ch]),
         .i_load(load_reg[ch]),
         .i_mode(mode_reg[ch]),
         .i_bcd(bcd_reg[ch]),
         .i_value(value_reg[ch]),
         .o_count(cnt_w[ch]),
         .o_out(o_out[ch])
      );

      a_latch_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
         (i_ce && cmd_latch && !latched_reg[ch]) |=>
         latched_reg[ch] && latch_val_reg[ch] == $past(cnt_w[ch]))
         else $error("latch command missed the count");
      a_latch_frozen: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
         latched_reg[ch] |=> $stable(latch_val_reg[ch]))
         else $error("snapshot changed while held");
      a_latch_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
         (i_ce && latched_reg[ch] && rd_done && rw_reg[ch] == ITCR_RW_BOTH && !rflip_reg[ch] &&
          !cw_set) |=> latched_reg[ch] && rflip_reg[ch])
         else $error("snapshot released after first byte");
      a_latch_release: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
         (i_ce && latched_reg[ch] && rd_done && rw_reg[ch] == ITCR_RW_BOTH && rflip_reg[ch] &&
          !cw_set) |=> !latched_reg[ch] && !rflip_reg[ch])
         else $error("snapshot not released after last byte");
   end

   // ==========================================================
   // Read data pins, registered; driven while chip and read selected at a counter address
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         data_reg <= ITCR_DATA_RST;
         oe_b_reg <= 1'b1;
      end else if (i_ce) begin
         oe_b_reg <= !(!i_cs_b && !i_rd_b && i_addr != ITCR_ADDR_CTRL);
         if (i_addr != ITCR_ADDR_CTRL && i_addr < 2'(NUM_CH)) begin
            data_reg <= rd_byte[i_addr];
         end else begin
            data_reg <= ITCR_DATA_RST;
         end
      end
   end

   assign o_data = data_reg;
   assign o_data_oe_b = oe_b_reg;

   a_read_live: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && !i_cs_b && !i_rd_b && i_addr == 2'h0 && !latched_reg[0] &&
       (rw_reg[0] == ITCR_RW_LSB || (rw_reg[0] == ITCR_RW_BOTH && !rflip_reg[0])))
      |=> !o_data_oe_b && o_data == $past(cnt_w[0][7:0]))
      else $error("direct read did not return live count");

endmodule : itcr_top
`default_nettype wire

/* File: sim/itcr_host.sv */
/*
 Host model: byte writes and reads on the timer's parallel bus.
 Assumes its tasks are called from a process synchronous to i_mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module itcr_host (
   input wire logic i_mclk,
   output logic o_cs_b,
   output logic o_rd_b,
   output logic o_wr_b,
   output logic [1:0] o_addr,
   output logic [7:0] o_data,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe_b
);
   // ==========================================================
   // Idle bus
   initial begin
      o_cs_b = 1'b1;
      o_rd_b = 1'b1;
      o_wr_b = 1'b1;
      o_addr = 2'h0;
      o_data = 8'h00;
   end

   // ==========================================================
   // Write: strobe low one clk, taken when seen high again
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_cs_b <= 1'b0;
      o_wr_b <= 1'b0;
      o_addr <= a;
      o_data <= d;
      @(posedge i_mclk);
      o_wr_b <= 1'b1;
      @(posedge i_mclk);
      o_cs_b <= 1'b1;
      // Inverted so a stale byte never looks valid
      o_data <= ~d;
   endtask : wr

   // ==========================================================
   // Read: byte is registered, taken two edges after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe_b);
      @(posedge i_mclk);
      o_cs_b <= 1'b0;
      o_rd_b <= 1'b0;
      o_addr <= a;
      repeat (2) @(posedge i_mclk);
      d = i_data;
      oe_b = i_data_oe_b;
      o_rd_b <= 1'b1;
      // Select held one clk past the strobe, else the byte pointer never advances
      @(posedge i_mclk);
      o_cs_b <= 1'b1;
   endtask : rd
endmodule : itcr_host
`default_nettype wire

/* File: sim/itcr_tb_top.sv */
/*
 Self-checking bench: rate, square, terminal count, latch, cascade, strobe.
 Assumes itcr_host drives the bus; counter clocks come from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module itcr_tb_top;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [2:0] cnt_reg = 3'h0;
   logic [2:0] gate_reg = 3'h7;
   logic casc_reg = 1'b0;
   logic cs_b;
   logic rd_b;
   logic wr_b;
   logic [1:0] addr;
   logic [7:0] h_data;
   logic [7:0] d_data;
   logic d_oe_b;
   logic [2:0] out;
   wire [7:0] bus;
   wire [2:0] cnt_clk;
   int bad_count = 0;
   int checks = 0;
   logic [15:0] v;

   always #5 i_mclk = ~i_mclk;
   assign bus = d_oe_b ? h_data : d_data;
   // Cascade: low-order output clocks the high-order counter
   assign cnt_clk = {cnt_reg[2], casc_reg ? out[0] : cnt_reg[1], cnt_reg[0]};

   itcr_host itcr_host_inst (.i_mclk(i_mclk), .o_cs_b(cs_b), .o_rd_b(rd_b), .o_wr_b(wr_b),
      .o_addr(addr), .o_data(h_data), .i_data(bus), .i_data_oe_b(d_oe_b));
   itcr_top #(.NUM_CH(3)) itcr_top_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(1'b1),
      .i_cs_b(cs_b), .i_rd_b(rd_b), .i_wr_b(wr_b), .i_addr(addr), .i_data(bus),
      .o_data(d_data), .o_data_oe_b(d_oe_b), .i_cnt_clk(cnt_clk), .i_gate(gate_reg), .o_out(out));

   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int ch, input int n);
      repeat (n) begin
         @(posedge i_mclk);
         cnt_reg[ch] <= 1'b1;
         repeat (3) @(posedge i_mclk);
         cnt_reg[ch] <= 1'b0;
         repeat (3) @(posedge i_mclk);
      end
   endtask : tick

   task automatic ld(input logic [1:0] ch, input logic [7:0] cw, input logic [15:0] n);
      itcr_host_inst.wr(2'h3, cw);
      itcr_host_inst.wr(ch, n[7:0]);
      itcr_host_inst.wr(ch, n[15:8]);
      repeat (2) @(posedge i_mclk);
   endtask : ld

   task automatic rd16(input logic [1:0] ch, output logic [15:0] r);
      logic oe0;
      logic oe1;
      itcr_host_inst.rd(ch, r[7:0], oe0);
      itcr_host_inst.rd(ch, r[15:8], oe1);
      chk({14'h0000, oe0, oe1}, 16'h0000);
   endtask : rd16

   task automatic summarize();
      if (bad_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // Scenarios
   task automatic s_rate();
      int lows;
      lows = 0;
      ld(2'h0, 8'h34, 16'h0004);
      tick(0, 1);
      for (int i = 0; i < 12; i++) begin
         tick(0, 1);
         if (out[0] === 1'b0) lows++;
      end
      chk(16'(lows), 16'h0003);
      // Halt before a direct read, reads are not synchronised
      gate_reg[0] <= 1'b0;
      rd16(2'h0, v);
      chk(v, 16'h0004);
   endtask : s_rate

   task automatic s_square();
      ld(2'h1, 8'h76, 16'h000A);
      tick(1, 2);
      itcr_host_inst.wr(2'h3, 8'h40);
      tick(1, 2);
      rd16(2'h1, v);
      chk(v, 16'h0008);
      gate_reg[1] <= 1'b0;
      rd16(2'h1, v);
      chk(v, 16'h0004);
   endtask : s_square

   task automatic s_term();
      ld(2'h2, 8'hB0, 16'h0003);
      chk({15'h0000, out[2]}, 16'h0000);
      tick(2, 3);
      chk({15'h0000, out[2]}, 16'h0000);
      tick(2, 1);
      chk({15'h0000, out[2]}, 16'h0001);
      tick(2, 3);
      chk({15'h0000, out[2]}, 16'h0001);
      ld(2'h2, 8'hB0, 16'h0000);
      tick(2, 2);
      gate_reg[2] <= 1'b0;
      rd16(2'h2, v);
      chk(v, 16'hFFFF);
   endtask : s_term

   task automatic s_casc();
      gate_reg[0] <= 1'b1;
      gate_reg[1] <= 1'b1;
      ld(2'h0, 8'h34, 16'h0002);
      casc_reg <= 1'b1;
      ld(2'h1, 8'h70, 16'h0002);
      tick(0, 5);
      chk({15'h0000, out[1]}, 16'h0000);
      tick(0, 2);
      chk({15'h0000, out[1]}, 16'h0001);
   endtask : s_casc

   // Software strobe, BCD, low byte only: latch then live readback
   task automatic s_strobe();
      logic [7:0] b;
      logic oe;
      gate_reg[2] <= 1'b1;
      itcr_host_inst.wr(2'h3, 8'h99);
      itcr_host_inst.wr(2'h2, 8'h10);
      repeat (2) @(posedge i_mclk);
      tick(2, 3);
      itcr_host_inst.wr(2'h3, 8'h80);
      tick(2, 1);
      itcr_host_inst.rd(2'h2, b, oe);
      chk({7'h00, oe, b}, 16'h0008);
      tick(2, 6);
      chk({15'h0000, out[2]}, 16'h0001);
      tick(2, 1);
      chk({15'h0000, out[2]}, 16'h0000);
      tick(2, 1);
      chk({15'h0000, out[2]}, 16'h0001);
      itcr_host_inst.rd(2'h2, b, oe);
      chk({7'h00, oe, b}, 16'h0000);
   endtask : s_strobe

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (3) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      s_rate();
      s_square();
      s_term();
      s_casc();
      s_strobe();
      summarize();
   end

   // Whole run needs well under 5000 clocks
   initial begin
      repeat (20000) @(posedge i_mclk);
      bad_count++;
      summarize();
   end
endmodule : itcr_tb_top
`default_nettype wire
